// [dmss_pkg.sv]
// Shared constants for the display mode switch sequencer
package dmss_pkg;
    // Bus byte offsets
    localparam logic [7:0] OFS_OPMODE    = 8'h00;
    localparam logic [7:0] OFS_APER_CTL  = 8'h04;
    localparam logic [7:0] OFS_INT_EN    = 8'h10;
    localparam logic [7:0] OFS_INT_STS   = 8'h14;
    localparam logic [7:0] OFS_APER_IDX  = 8'h20;
    localparam logic [7:0] OFS_EXT_IDX   = 8'h28;
    localparam logic [7:0] OFS_EXT_DATA  = 8'h2C;
    localparam logic [7:0] OFS_CRTC_IDX  = 8'h40;
    localparam logic [7:0] OFS_CRTC_DATA = 8'h44;
    localparam logic [7:0] OFS_SEQ_IDX   = 8'h48;
    localparam logic [7:0] OFS_SEQ_DATA  = 8'h4C;
    localparam logic [7:0] OFS_ATTR      = 8'h50;
    localparam logic [7:0] OFS_INSTAT    = 8'h54;
    localparam logic [7:0] OFS_COMPAT_EN = 8'h58;
    localparam logic [7:0] OFS_STATUS    = 8'h5C;
    // Extended indexed registers
    localparam logic [6:0] EXT_HSYNC_LO  = 7'h1A;
    localparam logic [6:0] EXT_HSYNC_HI  = 7'h1B;
    localparam logic [6:0] EXT_VSYNC_END = 7'h2A;
    localparam logic [6:0] EXT_MODE1     = 7'h50;
    localparam logic [6:0] EXT_MODE2     = 7'h51;
    localparam logic [6:0] EXT_CLK_SEL   = 7'h54;
    localparam logic [6:0] EXT_PAL_MASK  = 7'h64;
    localparam logic [6:0] EXT_XCLK_SEL  = 7'h70;
    // Field positions and codes
    localparam int         M1_FBE_BIT    = 4;
    localparam logic [1:0] M1_ARM        = 2'h1;
    localparam logic [1:0] M1_HOLD       = 2'h0;
    localparam logic [1:0] M1_RUN        = 2'h3;
    localparam int         VSYNC_BLK_BIT = 5;
    localparam int         XCLK_INT_BIT  = 7;
    localparam logic [2:0] OPM_COMPAT    = 3'h1;
    localparam logic [2:0] OPM_TEXT132   = 3'h3;
    localparam logic [4:0] CRTC_LOCK_IDX = 5'h11;
    localparam int         CRTC_LOCK_BIT = 7;
    localparam logic [4:0] CRTC_LOCK_TOP = 5'h07;
    localparam logic [2:0] SEQ_CLKM_IDX  = 3'h1;
    localparam logic [4:0] ATTR_MODE_IDX = 5'h13;
    localparam int         ATTR_PAL_BIT  = 5;
    localparam logic [1:0] APER_SEL_A    = 2'h1;
    localparam logic [1:0] APER_SEL_B    = 2'h2;
    localparam logic [19:0] APER_BASE_A  = 20'hA0000;
    localparam logic [19:0] APER_BASE_B  = 20'hB0000;
    localparam int         APER_WIN_SH   = 16;
    localparam logic [19:0] TEXT_BASE    = 20'hB8000;
    localparam logic [7:0] COLS_TEXT132  = 8'h84;
    localparam logic [7:0] COLS_COMPAT   = 8'h50;
    localparam logic [7:0] BYTE_RST      = 8'h00;
    localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;
    // Timing controller reset sequence
    typedef enum logic [1:0] {CRTC_RUNNING, CRTC_ARMED, CRTC_HELD} dmss_crtc_e;
endpackage : dmss_pkg

// [dmss_regfile.sv]
// Indexed byte register file with flat readout
`timescale 1ns/1ps
module dmss_regfile #(
    parameter int DEPTH = 128,
    parameter int AW    = 7
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [7:0]    wr_data,
    // Contents
    output logic      [7:0]    regs [DEPTH]
);
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            wire hit = wr_en && (wr_idx == AW'(g));
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) regs[g] <= dmss_pkg::BYTE_RST;
                else if (hit) regs[g] <= wr_data;
            end
        end
    endgenerate
endmodule : dmss_regfile

// [dmss_attr.sv]
// Attribute controller index/data port
`timescale 1ns/1ps
module dmss_attr (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    // Port accesses
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    input  wire logic       flip_clr,
    // State
    output logic            data_phase_ff,
    output logic      [4:0] index_ff,
    output logic            pal_en_ff,
    output logic      [7:0] mode_ff
);
    wire idx_wr  = wr_en && !data_phase_ff;
    wire data_wr = wr_en && data_phase_ff;
    wire mode_wr = data_wr && (index_ff == dmss_pkg::ATTR_MODE_IDX);

    // Status read forces the index phase, even over a write
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) data_phase_ff <= 1'b0;
        else if (flip_clr) data_phase_ff <= 1'b0;
        else if (wr_en) data_phase_ff <= !data_phase_ff;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            index_ff  <= 5'h00;
            pal_en_ff <= 1'b0;
        end else if (idx_wr) begin
            index_ff  <= wr_data[4:0];
            pal_en_ff <= wr_data[dmss_pkg::ATTR_PAL_BIT];
        end
    end

    // Only the mode register is kept; other palette data is dropped
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) mode_ff <= dmss_pkg::BYTE_RST;
        else if (mode_wr) mode_ff <= wr_data;
    end
endmodule : dmss_attr

// [dmss_top.sv]
// Mode switch register block of the display subsystem
//
// The placing of the registers and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module dmss_top #(
    parameter bit APER_1M_PRESENT = 1'b1,
    parameter bit APER_4M_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Display events
    input  wire logic        frame_start,
    // Display pipeline controls
    output logic             frame_buffer_enable,
    output logic             timing_reset,
    output logic             compat_mode,
    output logic             text132_mode,
    output logic             compat_decode_en,
    output logic      [7:0]  pixel_clk_sel,
    output logic             int_clk_sel,
    output logic             vsync_irq_block,
    output logic      [7:0]  scale_factors,
    output logic      [7:0]  palette_mask,
    output logic             palette_enable,
    output logic             char_8dot,
    output logic             crtc_locked,
    // Text buffer
    output logic      [19:0] text_base_addr,
    output logic      [7:0]  text_columns,
    // Apertures
    output logic             aper64_en,
    output logic      [19:0] aper64_base,
    output logic      [21:0] aper_window_ofs,
    output logic             aper1m_en,
    output logic             aper4m_en
);
    // Bus handshake
    logic        wait_ff;
    wire         req    = avs_read || avs_write;
    wire         accept = req && !wait_ff;
    wire         wr_acc = avs_write && !wait_ff && avs_byteenable[0];
    wire         rd_acc = avs_read && !wait_ff;
    wire  [7:0]  wd     = avs_writedata[7:0];
    wire  [7:0]  ofs    = {avs_address[7:2], 2'b00};

    // One wait state keeps read data registered
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) wait_ff <= 1'b1;
        else wait_ff <= !(req && wait_ff);
    end

    // Plain registers
    logic [2:0] opmode_ff;
    logic [7:0] aper_ctl_ff;
    logic [7:0] int_en_ff;
    logic [7:0] int_sts_ff;
    logic [7:0] aper_idx_ff;
    logic [6:0] ext_idx_ff;
    logic [4:0] crtc_idx_ff;
    logic [2:0] seq_idx_ff;
    logic [7:0] seq_clkm_ff;
    logic       compat_en_ff;
    dmss_pkg::dmss_crtc_e crtc_st_ff;
    dmss_pkg::dmss_crtc_e nxt_crtc_st;

    wire wr_opmode  = wr_acc && ofs == dmss_pkg::OFS_OPMODE;
    wire wr_aper    = wr_acc && ofs == dmss_pkg::OFS_APER_CTL;
    wire wr_int_en  = wr_acc && ofs == dmss_pkg::OFS_INT_EN;
    wire wr_int_sts = wr_acc && ofs == dmss_pkg::OFS_INT_STS;
    wire wr_apidx   = wr_acc && ofs == dmss_pkg::OFS_APER_IDX;
    wire wr_ext_idx = wr_acc && ofs == dmss_pkg::OFS_EXT_IDX;
    wire wr_ext_dat = wr_acc && ofs == dmss_pkg::OFS_EXT_DATA;
    wire wr_crtc_ix = wr_acc && ofs == dmss_pkg::OFS_CRTC_IDX;
    wire wr_crtc_dt = wr_acc && ofs == dmss_pkg::OFS_CRTC_DATA;
    wire wr_seq_idx = wr_acc && ofs == dmss_pkg::OFS_SEQ_IDX;
    wire wr_seq_dat = wr_acc && ofs == dmss_pkg::OFS_SEQ_DATA;
    wire wr_attr    = wr_acc && ofs == dmss_pkg::OFS_ATTR;
    wire wr_cmp_en  = wr_acc && ofs == dmss_pkg::OFS_COMPAT_EN;
    wire rd_instat  = rd_acc && ofs == dmss_pkg::OFS_INSTAT;

    // Extended and compatible timing register files
    logic [7:0] ext_regs [128];
    logic [7:0] crtc_regs [32];
    dmss_regfile #(.DEPTH(128), .AW(7)) u_ext (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .wr_en   (wr_ext_dat),
        .wr_idx  (ext_idx_ff),
        .wr_data (wd),
        .regs    (ext_regs)
    );

    wire lock_bit  = crtc_regs[dmss_pkg::CRTC_LOCK_IDX][dmss_pkg::CRTC_LOCK_BIT];
    wire crtc_prot = lock_bit && (crtc_idx_ff <= dmss_pkg::CRTC_LOCK_TOP);
    wire crtc_we   = wr_crtc_dt && !crtc_prot;
    dmss_regfile #(.DEPTH(32), .AW(5)) u_crtc (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .wr_en   (crtc_we),
        .wr_idx  (crtc_idx_ff),
        .wr_data (wd),
        .regs    (crtc_regs)
    );

    logic       attr_phase;
    logic [4:0] attr_idx;
    logic       attr_pal;
    logic [7:0] attr_mode;
    dmss_attr u_attr (
        .clk_sys       (clk_sys),
        .rstn          (rstn),
        .wr_en         (wr_attr),
        .wr_data       (wd),
        .flip_clr      (rd_instat),
        .data_phase_ff (attr_phase),
        .index_ff      (attr_idx),
        .pal_en_ff     (attr_pal),
        .mode_ff       (attr_mode)
    );

    wire vs_blk  = ext_regs[dmss_pkg::EXT_VSYNC_END][dmss_pkg::VSYNC_BLK_BIT];
    wire vs_set  = frame_start && int_en_ff[0] && !vs_blk;
    // Set wins over a simultaneous write-one clear
    wire [7:0] nxt_int_sts = (int_sts_ff & ~(wr_int_sts ? wd : 8'h00)) | {7'h00, vs_set};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            opmode_ff    <= 3'h0;
            aper_ctl_ff  <= dmss_pkg::BYTE_RST;
            int_en_ff    <= dmss_pkg::BYTE_RST;
            int_sts_ff   <= dmss_pkg::BYTE_RST;
            aper_idx_ff  <= dmss_pkg::BYTE_RST;
            ext_idx_ff   <= 7'h00;
            crtc_idx_ff  <= 5'h00;
            seq_idx_ff   <= 3'h0;
            seq_clkm_ff  <= dmss_pkg::BYTE_RST;
            compat_en_ff <= 1'b0;
        end else begin
            if (wr_opmode) opmode_ff <= wd[2:0];
            if (wr_aper) aper_ctl_ff <= wd;
            if (wr_int_en) int_en_ff <= wd;
            int_sts_ff <= nxt_int_sts;
            if (wr_apidx) aper_idx_ff <= wd;
            if (wr_ext_idx) ext_idx_ff <= wd[6:0];
            if (wr_crtc_ix) crtc_idx_ff <= wd[4:0];
            if (wr_seq_idx) seq_idx_ff <= wd[2:0];
            if (wr_seq_dat && seq_idx_ff == dmss_pkg::SEQ_CLKM_IDX) seq_clkm_ff <= wd;
            if (wr_cmp_en) compat_en_ff <= wd[0];
        end
    end

    // Low bits walk arm, hold, run
    wire       wr_mode1 = wr_ext_dat && ext_idx_ff == dmss_pkg::EXT_MODE1;
    wire [1:0] m1_code  = wd[1:0];
    always_comb begin
        nxt_crtc_st = crtc_st_ff;
        if (wr_mode1) begin
            if (m1_code == dmss_pkg::M1_RUN) nxt_crtc_st = dmss_pkg::CRTC_RUNNING;
            else if (m1_code == dmss_pkg::M1_ARM && crtc_st_ff != dmss_pkg::CRTC_HELD)
                nxt_crtc_st = dmss_pkg::CRTC_ARMED;
            // Hold is only reached through arming, so a stray 00h is harmless
            else if (m1_code == dmss_pkg::M1_HOLD && crtc_st_ff != dmss_pkg::CRTC_RUNNING)
                nxt_crtc_st = dmss_pkg::CRTC_HELD;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) crtc_st_ff <= dmss_pkg::CRTC_RUNNING;
        else crtc_st_ff <= nxt_crtc_st;
    end

    // Read mux
    wire [31:0] status_word = {14'h0000, attr_mode, attr_phase, attr_pal, crtc_prot, lock_bit,
                               compat_en_ff, opmode_ff, crtc_st_ff == dmss_pkg::CRTC_HELD,
                               crtc_st_ff == dmss_pkg::CRTC_ARMED};
    logic [31:0] rd_mux;
    always_comb begin
        unique case (ofs)
            dmss_pkg::OFS_OPMODE:    rd_mux = {29'h0, opmode_ff};
            dmss_pkg::OFS_APER_CTL:  rd_mux = {24'h0, aper_ctl_ff};
            dmss_pkg::OFS_INT_EN:    rd_mux = {24'h0, int_en_ff};
            dmss_pkg::OFS_INT_STS:   rd_mux = {24'h0, int_sts_ff};
            dmss_pkg::OFS_APER_IDX:  rd_mux = {24'h0, aper_idx_ff};
            dmss_pkg::OFS_EXT_IDX:   rd_mux = {25'h0, ext_idx_ff};
            dmss_pkg::OFS_EXT_DATA:  rd_mux = {24'h0, ext_regs[ext_idx_ff]};
            dmss_pkg::OFS_CRTC_IDX:  rd_mux = {27'h0, crtc_idx_ff};
            dmss_pkg::OFS_CRTC_DATA: rd_mux = {24'h0, crtc_regs[crtc_idx_ff]};
            dmss_pkg::OFS_SEQ_IDX:   rd_mux = {29'h0, seq_idx_ff};
            dmss_pkg::OFS_SEQ_DATA:  rd_mux = {24'h0, seq_clkm_ff};
            dmss_pkg::OFS_ATTR:      rd_mux = {26'h0, attr_pal, attr_idx};
            dmss_pkg::OFS_INSTAT:    rd_mux = {31'h0, attr_phase};
            dmss_pkg::OFS_COMPAT_EN: rd_mux = {31'h0, compat_en_ff};
            dmss_pkg::OFS_STATUS:    rd_mux = status_word;
            default:                 rd_mux = dmss_pkg::WORD_ZERO;
        endcase
    end

    // Derived display controls
    wire is_compat = opmode_ff == dmss_pkg::OPM_COMPAT;
    wire is_text   = opmode_ff == dmss_pkg::OPM_TEXT132;
    wire [1:0] aper_sel = aper_ctl_ff[1:0];
    wire [21:0] win_ofs = {aper_idx_ff[5:0], 16'h0000};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            avs_readdata        <= dmss_pkg::WORD_ZERO;
            avs_waitrequest     <= 1'b1;
            frame_buffer_enable <= 1'b0;
            timing_reset        <= 1'b0;
            compat_mode         <= 1'b0;
            text132_mode        <= 1'b0;
            compat_decode_en    <= 1'b0;
            pixel_clk_sel       <= dmss_pkg::BYTE_RST;
            int_clk_sel         <= 1'b0;
            vsync_irq_block     <= 1'b0;
            scale_factors       <= dmss_pkg::BYTE_RST;
            palette_mask        <= dmss_pkg::BYTE_RST;
            palette_enable      <= 1'b0;
            char_8dot           <= 1'b0;
            crtc_locked         <= 1'b0;
            text_base_addr      <= dmss_pkg::TEXT_BASE;
            text_columns        <= dmss_pkg::COLS_COMPAT;
            aper64_en           <= 1'b0;
            aper64_base         <= dmss_pkg::APER_BASE_A;
            aper_window_ofs     <= 22'h000000;
            aper1m_en           <= 1'b0;
            aper4m_en           <= 1'b0;
        end else begin
            avs_readdata        <= rd_mux;
            avs_waitrequest     <= !(req && wait_ff);
            frame_buffer_enable <= ext_regs[dmss_pkg::EXT_MODE1][dmss_pkg::M1_FBE_BIT];
            timing_reset        <= nxt_crtc_st == dmss_pkg::CRTC_HELD;
            compat_mode         <= is_compat;
            text132_mode        <= is_text;
            compat_decode_en    <= compat_en_ff && (is_compat || is_text);
            pixel_clk_sel       <= ext_regs[dmss_pkg::EXT_CLK_SEL];
            int_clk_sel         <= ext_regs[dmss_pkg::EXT_XCLK_SEL][dmss_pkg::XCLK_INT_BIT];
            vsync_irq_block     <= vs_blk;
            scale_factors       <= ext_regs[dmss_pkg::EXT_MODE2];
            palette_mask        <= ext_regs[dmss_pkg::EXT_PAL_MASK];
            palette_enable      <= attr_pal;
            char_8dot           <= seq_clkm_ff[0];
            crtc_locked         <= lock_bit;
            text_base_addr      <= dmss_pkg::TEXT_BASE;
            text_columns        <= is_text ? dmss_pkg::COLS_TEXT132 : dmss_pkg::COLS_COMPAT;
            aper64_en           <= aper_sel == dmss_pkg::APER_SEL_A || aper_sel == dmss_pkg::APER_SEL_B;
            aper64_base         <= aper_sel == dmss_pkg::APER_SEL_B ? dmss_pkg::APER_BASE_B
                                                                    : dmss_pkg::APER_BASE_A;
            aper_window_ofs     <= win_ofs;
            aper1m_en           <= APER_1M_PRESENT;
            aper4m_en           <= APER_4M_PRESENT;
        end
    end

    // Unused upper write data and byte lanes are ignored by design
    wire unused_ok = accept;
endmodule : dmss_top

// [dmss_top_properties.sv]
// Bus and control-output assertions for the mode switch block
`timescale 1ns/1ps
module dmss_top_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // Bus
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    // Controls
    input wire logic        frame_buffer_enable,
    input wire logic        timing_reset,
    input wire logic        compat_mode,
    input wire logic        text132_mode,
    input wire logic        compat_decode_en,
    input wire logic        crtc_locked,
    input wire logic [19:0] text_base_addr,
    input wire logic [7:0]  text_columns,
    input wire logic [21:0] aper_window_ofs
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Age since last data ack; saturates so idle periods stay cheap
    logic [1:0] ext_age_ff;
    logic [1:0] crtc_age_ff;
    wire        ack = avs_write && !avs_waitrequest;
    wire [1:0]  nxt_ext_age = (ack && avs_address[7:2] == 6'h0B) ? 2'h0 : ext_age_ff + {1'b0, ext_age_ff != 2'h3};
    wire [1:0]  nxt_crtc_age = (ack && avs_address[7:2] == 6'h11) ? 2'h0 : crtc_age_ff + {1'b0, crtc_age_ff != 2'h3};
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ext_age_ff  <= 2'h3;
            crtc_age_ff <= 2'h3;
        end else begin
            ext_age_ff  <= nxt_ext_age;
            crtc_age_ff <= nxt_crtc_age;
        end
    end
    sequence s_req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest;
    endsequence
    a_wait_one_state: assert property (s_req_wait |=> s_ack) else $error("no ack after one wait state");
    a_ack_single_cycle: assert property (s_ack |=> avs_waitrequest) else $error("ack longer than one cycle");
    a_treset_cause: assert property ($changed(timing_reset) |-> ext_age_ff <= 2'h2)
        else $error("timing reset moved without mode write");
    a_fbe_cause: assert property ($changed(frame_buffer_enable) |-> ext_age_ff <= 2'h2)
        else $error("frame buffer enable moved without mode write");
    a_lock_cause: assert property ($changed(crtc_locked) |-> crtc_age_ff <= 2'h2)
        else $error("lock moved without timing register write");
    a_modes_exclusive: assert property (!(compat_mode && text132_mode))
        else $error("two modes at once");
    a_decode_mode: assert property (compat_decode_en |-> compat_mode || text132_mode)
        else $error("decode enabled outside compatible modes");
    a_text_cols: assert property ($rose(text132_mode) |-> ##[0:1] text_columns == 8'h84)
        else $error("text row width wrong");
    a_text_base: assert property (text_base_addr == 20'hB8000)
        else $error("text base wrong");
    a_window_align: assert property (aper_window_ofs[15:0] == 16'h0000)
        else $error("window not 64K aligned");
endmodule : dmss_top_checker
bind dmss_top dmss_top_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .frame_buffer_enable(frame_buffer_enable), .timing_reset(timing_reset), .compat_mode(compat_mode),
    .text132_mode(text132_mode), .compat_decode_en(compat_decode_en), .crtc_locked(crtc_locked),
    .text_base_addr(text_base_addr), .text_columns(text_columns), .aper_window_ofs(aper_window_ofs));

// [dmss_host_model.sv]
// Host processor model: bus master issuing register accesses
`timescale 1ns/1ps
module dmss_host_model (
    // Clock
    input wire logic        clk_sys,
    // Bus
    output logic     [7:0]  avs_address,
    output logic            avs_read,
    output logic            avs_write,
    output logic     [31:0] avs_writedata,
    output logic     [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0000_0000;
        avs_byteenable = 4'hF;
    end
    // One access; held until waitrequest is sampled low
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] be,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= !w;
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        if (n >= 50) test_dmss_top.hang();
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        // Stale data would hide a slave that samples late
        avs_writedata <= ~{24'h00_0000, d};
    endtask : xfer
endmodule : dmss_host_model

// [test_dmss_top.sv]
// Self-checking bench for the mode switch block
`timescale 1ns/1ps
module test_dmss_top;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        frame_start = 1'b0;
    logic [7:0]  avs_address;
    logic        avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic        fbe, trst, cmode, tmode, cdec, iclk, vblk, pal, c8, lck, a64, a1m, a4m;
    logic [7:0]  pclk, scale, pmask, tcols;
    logic [19:0] tbase, a64b;
    logic [21:0] wofs;
    logic [7:0]  hvals [6] = '{8'hA4, 8'h83, 8'h84, 8'h83, 8'h90, 8'h80};
    int          failures = 0;
    int          check_count = 0;
    always #5 clk_sys = ~clk_sys;
    dmss_host_model host (.clk_sys(clk_sys), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    dmss_top uut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_start(frame_start),
        .frame_buffer_enable(fbe), .timing_reset(trst), .compat_mode(cmode), .text132_mode(tmode),
        .compat_decode_en(cdec), .pixel_clk_sel(pclk), .int_clk_sel(iclk), .vsync_irq_block(vblk),
        .scale_factors(scale), .palette_mask(pmask), .palette_enable(pal), .char_8dot(c8),
        .crtc_locked(lck), .text_base_addr(tbase), .text_columns(tcols), .aper64_en(a64),
        .aper64_base(a64b), .aper_window_ofs(wofs), .aper1m_en(a1m), .aper4m_en(a4m));
    task conclude;
        if (failures == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task hang;
        failures++;
        conclude();
    endtask : hang
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d, 4'hF, q);
    endtask : wr
    task rd(input logic [7:0] a);
        host.xfer(1'b0, a, 8'h00, 4'hF, q);
    endtask : rd
    task ext(input logic [7:0] i, input logic [7:0] d);
        wr(8'h28, i);
        wr(8'h2C, d);
    endtask : ext
    task crtc(input logic [7:0] i, input logic [7:0] d);
        wr(8'h40, i);
        wr(8'h44, d);
    endtask : crtc
    // Derived outputs other than timing_reset lag the write by one cycle
    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle
    initial begin
        repeat (6) @(posedge clk_sys);
        chk(avs_waitrequest, 1'b1);
        chk(tcols, 8'h50);
        rstn <= 1'b1;
        ext(8'h51, 8'h02);
        ext(8'h70, 8'h80);
        settle();
        chk(iclk, 1'b1);
        // display memory is cleared by the host outside this block
        // host order: aperture, interrupts, status, mask
        wr(8'h04, 8'h00);
        wr(8'h10, 8'h00);
        wr(8'h14, 8'hFF);
        ext(8'h64, 8'hFF);
        ext(8'h50, 8'h15);
        settle();
        chk(pmask, 8'hFF);
        chk(fbe, 1'b1);
        rd(8'h5C);
        chk(q[1:0], 2'h1);
        ext(8'h50, 8'h14);
        settle();
        chk({fbe, trst}, 2'h3);
        ext(8'h51, 8'h00);
        ext(8'h54, 8'h04);
        ext(8'h70, 8'h00);
        ext(8'h2A, 8'h20);
        wr(8'h10, 8'h01);
        settle();
        chk({scale, pclk, 7'h00, iclk, 7'h00, vblk}, 32'h0004_0001);
        @(posedge clk_sys);
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        rd(8'h14);
        chk(q[0], 1'b0);
        wr(8'h00, 8'h01);
        settle();
        chk({cmode, cdec}, 2'h2);
        wr(8'h58, 8'h01);
        settle();
        chk(cdec, 1'b1);
        host.xfer(1'b1, 8'h00, 8'h03, 4'hE, q);
        ext(8'h50, 8'h03);
        settle();
        chk({tmode, trst}, 2'h0);
        // set bit 0, then masked with FDh and FCh
        ext(8'h50, 8'h01);
        wr(8'h2C, 8'h01);
        wr(8'h2C, 8'h00);
        wr(8'h00, 8'h03);
        ext(8'h54, 8'h01);
        ext(8'h70, 8'h80);
        settle();
        chk(trst, 1'b1);
        chk({tmode, cmode, tcols, tbase}, {2'h2, 8'h84, 20'hB8000});
        chk({pclk, iclk}, 9'h003);
        crtc(8'h11, 8'h80);
        crtc(8'h00, 8'h55);
        crtc(8'h11, 8'h00);
        settle();
        chk(lck, 1'b0);
        for (int i = 0; i < 6; i++) crtc(i[7:0], hvals[i]);
        crtc(8'h13, 8'h42);
        ext(8'h1A, 8'hA3);
        ext(8'h1B, 8'h00);
        crtc(8'h11, 8'h80);
        crtc(8'h00, 8'h77);
        rd(8'h44);
        chk(q, 32'h0000_00A4);
        settle();
        chk(lck, 1'b1);
        ext(8'h50, 8'h03);
        wr(8'h48, 8'h01);
        wr(8'h4C, 8'h01);
        wr(8'h50, 8'h13);
        settle();
        chk({trst, c8}, 2'h1);
        rd(8'h54);
        chk(q[0], 1'b1);
        rd(8'h54);
        chk(q[0], 1'b0);
        wr(8'h50, 8'h13);
        wr(8'h50, 8'h00);
        wr(8'h50, 8'h20);
        settle();
        chk(pal, 1'b1);
        wr(8'h04, 8'h02);
        wr(8'h20, 8'h05);
        settle();
        chk({a1m, a4m, a64}, 3'h7);
        chk(a64b, 20'hB0000);
        chk(wofs, 22'h05_0000);
        rd(8'h7C);
        chk(q, 32'h0000_0000);
        rstn <= 1'b0;
        settle();
        chk({tmode, tcols}, 9'h050);
        conclude();
    end
endmodule : test_dmss_top
